//--- src/mcd_pkg.sv
package mcd_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] MCD_STAT_OFS = 8'h00; // mac_status_word
  localparam logic [7:0] MCD_CTRL_OFS = 8'h04; // mac_control_word
  localparam logic [7:0] MCD_REPW_OFS = 8'h08; // mac_repeat_word
  localparam logic [7:0] MCD_IST_OFS  = 8'h0c; // sticky event status, read only
  localparam logic [7:0] MCD_IEN_OFS  = 8'h10; // event enable
  localparam logic [7:0] MCD_ICLR_OFS = 8'h14; // event clear, write only
  localparam logic [7:0] MCD_ACCL_OFS = 8'h18; // accumulator bits 31:0
  localparam logic [7:0] MCD_ACCH_OFS = 8'h1c; // accumulator bits 39:32
  localparam logic [7:0] MCD_PTR_OFS  = 8'h20; // operand pointers y:x
  localparam logic [7:0] MCD_QOFS_OFS = 8'h24; // pointer offsets y:x

  // status word flag positions, trap enables sit at the same bits of the control word
  localparam int MCD_NEG_BIT  = 0; // result negative
  localparam int MCD_ZERO_BIT = 1; // result zero
  localparam int MCD_CARRY_BIT = 2; // carry out of bit 39
  localparam int MCD_EXT_BIT  = 3; // significant bits above bit 31
  localparam int MCD_OVFF_BIT = 4; // overflow_sticky_flag
  localparam int MCD_SATF_BIT = 5; // saturation_sticky_flag
  localparam int MCD_FLAG_W   = 6; // number of condition flags

  // control word mode bits
  localparam int MCD_SATEN_BIT  = 9;  // saturation_enable_bit
  localparam int MCD_PSHIFT_BIT = 10; // product_shift_mode

  // repeat word: count of extra iterations and a busy bit
  localparam int MCD_REP_W       = 13;
  localparam int MCD_REP_ACT_BIT = 15;

  // reset values
  localparam logic [15:0]          MCD_STAT_RST = 16'h0000;
  localparam logic [15:0]          MCD_CTRL_RST = 16'h0000;
  localparam logic [MCD_REP_W-1:0] MCD_REP_RST  = 13'h0000;

  // saturation targets, shifter limit and pointer step
  localparam logic [39:0] MCD_SAT_POS   = 40'h00_7fff_ffff;
  localparam logic [39:0] MCD_SAT_NEG   = 40'hff_8000_0000;
  localparam logic [3:0]  MCD_SHIFT_MAX = 4'h8;
  localparam logic [15:0] MCD_PTR_STEP  = 16'h0002;

  // event bits
  localparam int MCD_IRQ_DONE = 0;
  localparam int MCD_IRQ_SAT  = 1;
  localparam int MCD_IRQ_OVF  = 2;
  localparam int MCD_IRQ_TRAP = 3;
  localparam int MCD_IRQ_W    = 4;

  // coprocessor operations
  typedef enum logic [3:0] {
    MCD_OP_MUL, MCD_OP_MAC, MCD_OP_ADD, MCD_OP_SUB, MCD_OP_CMP, MCD_OP_SHL,
    MCD_OP_SHR, MCD_OP_LIM, MCD_OP_CLR, MCD_OP_STORE, MCD_OP_MOVE
  } mcd_op_type;

  // pointer post-modification modes
  typedef enum logic [2:0] {
    MCD_PM_NONE, MCD_PM_INC, MCD_PM_DEC, MCD_PM_ADDQ, MCD_PM_SUBQ
  } mcd_pm_type;

endpackage

//--- src/mcd_agu.sv
`timescale 1ns/1ps
module mcd_agu
  import mcd_pkg::*;
#(
  parameter int AW = 16 // pointer width
)(
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          load,
  input  wire logic [AW-1:0] load_x,
  input  wire logic [AW-1:0] load_y,
  input  wire logic          step,
  input  wire mcd_pm_type    mode_x,
  input  wire mcd_pm_type    mode_y,
  input  wire logic [AW-1:0] ofs_x,
  input  wire logic [AW-1:0] ofs_y,
  output logic      [AW-1:0] addr_x,
  output logic      [AW-1:0] addr_y,
  output logic      [AW-1:0] wb_addr
);

  typedef struct packed {
    logic [AW-1:0] px; // general pointer
    logic [AW-1:0] py; // index pointer, source of the parallel move
    logic [AW-1:0] wb; // write-back address of the parallel move
  } mcd_agu_type;

  mcd_agu_type s_q;
  mcd_agu_type s_d;

  // pointer update for one mode; illegal codes leave the pointer alone
  function automatic logic [AW-1:0] post_mod(input logic [AW-1:0] p,
                                             input mcd_pm_type    m,
                                             input logic [AW-1:0] q);
    case (m)
      MCD_PM_INC:  post_mod = p + AW'(MCD_PTR_STEP);
      MCD_PM_DEC:  post_mod = p - AW'(MCD_PTR_STEP);
      MCD_PM_ADDQ: post_mod = p + q;
      MCD_PM_SUBQ: post_mod = p - q;
      default:     post_mod = p;
    endcase
  endfunction

  // the move goes the opposite way to the pointer walk
  function automatic mcd_pm_type reverse(input mcd_pm_type m);
    case (m)
      MCD_PM_INC:  reverse = MCD_PM_DEC;
      MCD_PM_DEC:  reverse = MCD_PM_INC;
      MCD_PM_ADDQ: reverse = MCD_PM_SUBQ;
      MCD_PM_SUBQ: reverse = MCD_PM_ADDQ;
      default:     reverse = MCD_PM_NONE;
    endcase
  endfunction

  // software load wins over a step in the same cycle
  always_comb
  begin
    s_d = s_q;
    if (load)
    begin
      s_d.px = load_x;
      s_d.py = load_y;
    end
    else if (step)
    begin
      // both pointers move after their access, in one cycle
      s_d.px = post_mod(s_q.px, mode_x, ofs_x);
      s_d.py = post_mod(s_q.py, mode_y, ofs_y);
      s_d.wb = post_mod(s_q.py, reverse(mode_y), ofs_y);
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign addr_x  = s_q.px;
  assign addr_y  = s_q.py;
  assign wb_addr = s_q.wb;

  post_inc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (step && !load && mode_x == MCD_PM_INC) |=> addr_x == $past(addr_x) + AW'(MCD_PTR_STEP))
    else $error("pointer x did not advance by two");

endmodule

//--- src/mcd_top.sv
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
// Function
// - every operation takes exactly two execute cycles
// - 16x16 multiply, both signed or both unsigned
// - 40-bit signed accumulator with automatic saturation
// - repeat unit, up to 8192 iterations
// - pending interrupt breaks a repeat early
// - enabled condition flags raise a trap
// - two operands delivered each instruction cycle
// - parallel data move costs no cycle
// - double indirect pointers post-modified after access
// - fast register store and table move
// - three 16-bit status, control, repeat words
// - multiply, accumulate, 32-bit arithmetic, compare
// - saturation loads most positive or negative value
// - saturation flag sticky until software clears
// - 40-bit overflow flag sticky until cleared
// - product shift drops redundant sign bit
module mcd_top
  import mcd_pkg::*;
#(
  parameter int AW = 16 // operand address width
)(
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // instruction issue from the core
  input  wire logic          cmd_valid,
  input  wire mcd_op_type    cmd_op,
  input  wire logic          cmd_signed,
  input  wire logic          cmd_scale,
  input  wire logic          cmd_pmove,
  input  wire logic          cmd_rep,
  input  wire logic [3:0]    cmd_shift,
  input  wire logic [2:0]    cmd_sel,
  input  wire mcd_pm_type    cmd_mode_x,
  input  wire mcd_pm_type    cmd_mode_y,
  input  wire logic [15:0]   op_a,
  input  wire logic [15:0]   op_b,
  input  wire logic          intr_pend,
  output logic               cmd_ready,
  // results and moves back to the core
  output logic               res_valid,
  output logic      [15:0]   res_data,
  output logic               trap_b,
  output logic      [AW-1:0] addr_x,
  output logic      [AW-1:0] addr_y,
  output logic               mv_valid,
  output logic      [AW-1:0] mv_addr,
  output logic      [15:0]   mv_data,
  output logic               irq
);

  typedef enum logic [1:0] {MCD_IDLE, MCD_EX1, MCD_EX2} mcd_st_type;

  typedef struct packed {
    mcd_st_type             st;      // execute sequencer
    mcd_op_type             op;      // latched operation
    mcd_pm_type             mx;      // latched mode of pointer x
    mcd_pm_type             my;      // latched mode of pointer y
    logic                   sg;      // signed multiply
    logic                   sc;      // scale concatenation
    logic                   pm;      // parallel move requested
    logic                   ract;    // repeat in progress
    logic [3:0]             sh;      // shift amount
    logic [2:0]             sel;     // store source
    logic [15:0]            a;       // operand from pointer x
    logic [15:0]            b;       // operand from pointer y
    logic [31:0]            prod;    // product stage register
    logic [39:0]            acc;     // accumulator
    logic [15:0]            stw;     // mac_status_word
    logic [15:0]            ctw;     // mac_control_word
    logic [MCD_REP_W-1:0]   rep;     // mac_repeat_word count
    logic [15:0]            qx;      // offset for pointer x
    logic [15:0]            qy;      // offset for pointer y
    logic [MCD_IRQ_W-1:0]   ist;     // sticky events
    logic [MCD_IRQ_W-1:0]   ien;     // event enables
    logic                   rdy;     // ready for a command
    logic                   rv;      // result pulse
    logic [15:0]            rd;      // result data
    logic                   trap;    // trap pulse
    logic                   mv;      // move pulse
    logic [AW-1:0]          mva;     // move address
    logic [15:0]            mvd;     // move data
    logic                   irq;     // interrupt level
    logic                   sat_ev;  // saturation happened
    logic                   ovf_ev;  // 40-bit overflow happened
    logic                   pready;  // apb access phase answer
    logic                   pslverr; // unmapped address
    logic [31:0]            prdata;  // apb read data
  } mcd_state_type;

  localparam mcd_state_type RST_S = '{st: MCD_IDLE, op: MCD_OP_MUL, mx: MCD_PM_NONE,
    my: MCD_PM_NONE, stw: MCD_STAT_RST, ctw: MCD_CTRL_RST, rep: MCD_REP_RST,
    rdy: 1'b1, default: '0};

  mcd_state_type s_q;
  mcd_state_type s_d;

  logic               apb_set;  // setup phase
  logic               apb_wr;   // write takes effect
  logic               take;     // command accepted
  logic               loop;     // next repeat iteration starts
  logic               agu_load; // software loads pointers
  logic [AW-1:0]      wb_addr;  // parallel move target
  logic signed [33:0] prod34;   // raw multiplier output
  logic [39:0]        p40;      // extended, maybe shifted product
  logic [39:0]        c40;      // extended, maybe scaled concatenation
  logic [39:0]        bsrc;     // accumulator side of the adder
  logic [39:0]        asrc;     // operand side of the adder
  logic [40:0]        sum;      // adder with carry out
  logic [39:0]        res;      // datapath result
  logic [39:0]        res_f;    // result after saturation, what the accumulator takes
  logic [39:0]        lim;      // limited accumulator
  logic [3:0]         shc;      // clipped shift amount
  logic               arith;    // adder result is used
  logic               sub;      // subtract
  logic               ovf;      // signed 40-bit overflow
  logic               flg;      // op updates flags

  // clips a 40-bit value to the 32-bit signed range
  function automatic logic [39:0] limit32(input logic [39:0] x);
    if (x[39:31] == '0 || x[39:31] == '1)
      limit32 = x;
    else
      limit32 = x[39] ? MCD_SAT_NEG : MCD_SAT_POS;
  endfunction

  // true when bits 39:31 carry only sign
  function automatic logic fits32(input logic [39:0] x);
    fits32 = (x[39:31] == '0) || (x[39:31] == '1);
  endfunction

  // address decode for the error answer
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      MCD_STAT_OFS, MCD_CTRL_OFS, MCD_REPW_OFS, MCD_IST_OFS, MCD_IEN_OFS,
      MCD_ICLR_OFS, MCD_ACCL_OFS, MCD_ACCH_OFS, MCD_PTR_OFS, MCD_QOFS_OFS:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  endfunction

  assign apb_set  = psel && !penable;
  assign apb_wr   = psel && penable && pwrite && s_q.pready;
  assign agu_load = apb_wr && paddr == MCD_PTR_OFS;
  assign take     = s_q.st == MCD_IDLE && cmd_valid && s_q.rdy;
  // an interrupt waiting at the end of an iteration ends the repeat there
  assign loop = s_q.st == MCD_EX2 && s_q.ract && s_q.rep != '0 && !intr_pend;

  // both operands share one multiplier cycle; same signedness for both
  assign prod34 = $signed({s_q.sg & s_q.a[15], s_q.a}) *
                  $signed({s_q.sg & s_q.b[15], s_q.b});

  // address generator: both pointers step on every operand fetch
  mcd_agu #(
    .AW (AW)
  ) u_agu (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .load    (agu_load),
    .load_x  (AW'(pwdata[15:0])),
    .load_y  (AW'(pwdata[31:16])),
    .step    (take || loop),
    .mode_x  (take ? cmd_mode_x : s_q.mx),
    .mode_y  (take ? cmd_mode_y : s_q.my),
    .ofs_x   (AW'(s_q.qx)),
    .ofs_y   (AW'(s_q.qy)),
    .addr_x  (addr_x),
    .addr_y  (addr_y),
    .wb_addr (wb_addr)
  );

  // datapath in front of the accumulator
  always_comb
  begin
    p40 = {{8{s_q.sg & s_q.prod[31]}}, s_q.prod};
    if (s_q.ctw[MCD_PSHIFT_BIT])
      p40 = {p40[38:0], 1'b0};
    c40 = {{8{s_q.a[15]}}, s_q.a, s_q.b};
    if (s_q.sc)
      c40 = {c40[38:0], 1'b0};
    shc   = (s_q.sh > MCD_SHIFT_MAX) ? MCD_SHIFT_MAX : s_q.sh;
    lim   = limit32(s_q.acc);
    bsrc  = s_q.acc;
    asrc  = c40;
    arith = 1'b0;
    sub   = 1'b0;
    flg   = 1'b1;
    // operand selection per operation
    case (s_q.op)
      MCD_OP_MUL:
      begin
        bsrc  = '0;
        asrc  = p40;
        arith = 1'b1;
      end
      MCD_OP_MAC:
      begin
        asrc  = p40;
        arith = 1'b1;
      end
      MCD_OP_ADD:
        arith = 1'b1;
      MCD_OP_SUB, MCD_OP_CMP:
      begin
        arith = 1'b1;
        sub   = 1'b1;
      end
      default:
        arith = 1'b0;
    endcase
    if (sub)
      asrc = ~asrc;
    // 40-bit signed adder, a carry-in completes the subtraction
    sum = {1'b0, bsrc} + {1'b0, asrc} + {40'h0, sub};
    res = sum[39:0];
    ovf = (bsrc[39] == asrc[39]) && (res[39] != bsrc[39]);
    // non-adder results
    case (s_q.op)
      MCD_OP_SHL:   res = s_q.acc << shc;
      MCD_OP_SHR:   res = 40'($signed(s_q.acc) >>> shc);
      MCD_OP_LIM:   res = lim;
      MCD_OP_CLR:   res = '0;
      MCD_OP_STORE,
      MCD_OP_MOVE:
      begin
        res = s_q.acc;
        flg = 1'b0;
      end
      default:      res = res;
    endcase
  end

  // whole next state: bus slave first, then execution so hardware sets win
  always_comb
  begin
    s_d        = s_q;
    s_d.rv     = 1'b0;
    s_d.trap   = 1'b0;
    s_d.mv     = 1'b0;
    s_d.sat_ev = 1'b0;
    s_d.ovf_ev = 1'b0;
    // the datapath process owns res; saturation works on a copy of its own
    res_f      = res;
    // apb: answer in the cycle after setup, no wait states
    s_d.pready  = apb_set;
    s_d.pslverr = apb_set && !mapped(paddr);
    if (apb_set)
    begin
      case (paddr)
        MCD_STAT_OFS: s_d.prdata = {16'h0, s_q.stw};
        MCD_CTRL_OFS: s_d.prdata = {16'h0, s_q.ctw};
        MCD_REPW_OFS: s_d.prdata = {16'h0, s_q.ract, 2'b00, s_q.rep};
        MCD_IST_OFS:  s_d.prdata = {28'h0, s_q.ist};
        MCD_IEN_OFS:  s_d.prdata = {28'h0, s_q.ien};
        MCD_ACCL_OFS: s_d.prdata = s_q.acc[31:0];
        MCD_ACCH_OFS: s_d.prdata = {24'h0, s_q.acc[39:32]};
        MCD_PTR_OFS:  s_d.prdata = {16'(addr_y), 16'(addr_x)};
        MCD_QOFS_OFS: s_d.prdata = {s_q.qy, s_q.qx};
        default:      s_d.prdata = 32'h0;
      endcase
    end
    // writes land at the access edge; writing zero clears a sticky flag
    if (apb_wr)
    begin
      case (paddr)
        MCD_STAT_OFS: s_d.stw = pwdata[15:0];
        MCD_CTRL_OFS: s_d.ctw = pwdata[15:0];
        MCD_REPW_OFS: s_d.rep = pwdata[MCD_REP_W-1:0];
        MCD_IEN_OFS:  s_d.ien = pwdata[MCD_IRQ_W-1:0];
        MCD_ICLR_OFS: s_d.ist = s_q.ist & ~pwdata[MCD_IRQ_W-1:0];
        MCD_QOFS_OFS:
        begin
          s_d.qx = pwdata[15:0];
          s_d.qy = pwdata[31:16];
        end
        default:      s_d.ien = s_d.ien;
      endcase
    end
    // execute sequencer: operands, product, accumulate
    unique case (s_q.st)
      MCD_IDLE:
        if (take)
        begin
          s_d.st   = MCD_EX1;
          s_d.op   = cmd_op;
          s_d.mx   = cmd_mode_x;
          s_d.my   = cmd_mode_y;
          s_d.sg   = cmd_signed;
          s_d.sc   = cmd_scale;
          s_d.pm   = cmd_pmove;
          s_d.ract = cmd_rep;
          s_d.sh   = cmd_shift;
          s_d.sel  = cmd_sel;
          s_d.a    = op_a;
          s_d.b    = op_b;
        end
      MCD_EX1:
      begin
        // first execute cycle: product register
        s_d.prod = prod34[31:0];
        s_d.st   = MCD_EX2;
      end
      MCD_EX2:
      begin
        // saturate on a 32-bit overflow when enabled
        if (arith && s_q.op != MCD_OP_CMP && s_d.ctw[MCD_SATEN_BIT] &&
            (ovf || !fits32(res)))
        begin
          res_f      = (ovf ? ~res[39] : res[39]) ? MCD_SAT_NEG : MCD_SAT_POS;
          s_d.sat_ev = 1'b1;
        end
        s_d.ovf_ev = arith && ovf && s_q.op != MCD_OP_CMP;
        // compare sets flags only; store and move leave acc alone
        if (flg && s_q.op != MCD_OP_CMP)
          s_d.acc = res_f;
        if (flg)
        begin
          s_d.stw[MCD_NEG_BIT]   = res_f[39];
          s_d.stw[MCD_ZERO_BIT]  = res_f == '0;
          s_d.stw[MCD_CARRY_BIT] = arith && sum[40];
          s_d.stw[MCD_EXT_BIT]   = !fits32(res_f);
        end
        // sticky flags: the set wins over a software clear
        s_d.stw[MCD_SATF_BIT] = s_d.stw[MCD_SATF_BIT] | s_d.sat_ev;
        s_d.stw[MCD_OVFF_BIT] = s_d.stw[MCD_OVFF_BIT] | s_d.ovf_ev;
        s_d.rv = 1'b1;
        // result word: store reads registers without a pipeline gap
        if (s_q.op == MCD_OP_STORE)
          case (s_q.sel)
            3'h0:    s_d.rd = s_q.acc[15:0];
            3'h1:    s_d.rd = s_q.acc[31:16];
            3'h2:    s_d.rd = {8'h0, s_q.acc[39:32]};
            3'h3:    s_d.rd = s_q.stw;
            3'h4:    s_d.rd = s_q.ctw;
            3'h5:    s_d.rd = {s_q.ract, 2'b00, s_q.rep};
            3'h6:    s_d.rd = lim[15:0];
            default: s_d.rd = lim[31:16];
          endcase
        else if (s_q.op == MCD_OP_MOVE)
          s_d.rd = s_q.a;
        else
          s_d.rd = res_f[31:16];
        // table move writes to pointer y; parallel move to the reverse slot
        if (s_q.op == MCD_OP_MOVE)
        begin
          s_d.mv  = 1'b1;
          s_d.mva = addr_y;
          s_d.mvd = s_q.a;
        end
        else if (s_q.pm && s_q.op == MCD_OP_MAC)
        begin
          s_d.mv  = 1'b1;
          s_d.mva = wb_addr;
          s_d.mvd = s_q.b;
        end
        // trap on any enabled condition flag
        s_d.trap = |(s_d.stw[MCD_FLAG_W-1:0] & s_d.ctw[MCD_FLAG_W-1:0]);
        // repeat: next iteration or stop, remainder stays visible
        if (loop)
        begin
          s_d.rep = s_q.rep - 13'h1;
          s_d.a   = op_a;
          s_d.b   = op_b;
          s_d.st  = MCD_EX1;
        end
        else
        begin
          s_d.ract = 1'b0;
          s_d.st   = MCD_IDLE;
        end
      end
      default:
        s_d.st = MCD_IDLE;
    endcase
    s_d.rdy = s_d.st == MCD_IDLE;
    // events: set after clear so an event in the clear cycle survives
    s_d.ist[MCD_IRQ_DONE] = s_d.ist[MCD_IRQ_DONE] | s_d.rv;
    s_d.ist[MCD_IRQ_SAT]  = s_d.ist[MCD_IRQ_SAT] | s_d.sat_ev;
    s_d.ist[MCD_IRQ_OVF]  = s_d.ist[MCD_IRQ_OVF] | s_d.ovf_ev;
    s_d.ist[MCD_IRQ_TRAP] = s_d.ist[MCD_IRQ_TRAP] | s_d.trap;
    s_d.irq = |(s_d.ist & s_d.ien);
  end

  // state register
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= RST_S;
    else
      s_q <= s_d;
  end

  // all outputs straight from the state register
  assign prdata    = s_q.prdata;
  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign cmd_ready = s_q.rdy;
  assign res_valid = s_q.rv;
  assign res_data  = s_q.rd;
  assign trap_b    = s_q.trap;
  assign mv_valid  = s_q.mv;
  assign mv_addr   = s_q.mva;
  assign mv_data   = s_q.mvd;
  assign irq       = s_q.irq;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // accept, product cycle, accumulate cycle, result
  sequence s_two_exec;
    ##1 (s_q.st == MCD_EX1) ##1 (s_q.st == MCD_EX2) ##1 s_q.rv;
  endsequence

  sequence s_move_same;
    ##1 (s_q.st == MCD_EX2) ##1 (s_q.mv && s_q.rv);
  endsequence

  two_cycle_a: assert property (take |-> s_two_exec)
    else $error("operation did not finish in two execute cycles");

  rep_step_a: assert property (loop |=>
    (s_q.st == MCD_EX1 && s_q.rep == $past(s_q.rep) - 13'h1))
    else $error("repeat count did not step by one");

  rep_break_a: assert property ((s_q.st == MCD_EX2 && intr_pend) |=>
    (s_q.st == MCD_IDLE && !s_q.ract))
    else $error("repeat not broken by pending interrupt");

  trap_flag_a: assert property (s_q.rv |->
    s_q.trap == |(s_q.stw[MCD_FLAG_W-1:0] & s_q.ctw[MCD_FLAG_W-1:0]))
    else $error("trap does not match enabled flags");

  pmove_free_a: assert property ((s_q.st == MCD_EX1 && s_q.pm &&
    s_q.op == MCD_OP_MAC) |-> s_move_same)
    else $error("parallel move cost a cycle");

  sat_value_a: assert property (s_q.sat_ev |->
    (s_q.acc == MCD_SAT_POS || s_q.acc == MCD_SAT_NEG))
    else $error("saturated accumulator has wrong value");

  sat_sticky_a: assert property ((s_q.stw[MCD_SATF_BIT] &&
    !(apb_wr && paddr == MCD_STAT_OFS)) |=> s_q.stw[MCD_SATF_BIT])
    else $error("saturation flag dropped without a clear");

  ovf_sticky_a: assert property ((s_q.stw[MCD_OVFF_BIT] &&
    !(apb_wr && paddr == MCD_STAT_OFS)) |=> s_q.stw[MCD_OVFF_BIT])
    else $error("overflow flag dropped without a clear");

endmodule

//--- sim/mcd_mem_model.sv
`timescale 1ns/1ps
// operand memory: each word reads back its own address, so
// operands follow from the pointers alone
module mcd_mem_model
#(
  parameter int AW = 16 // pointer width
)(
  input  wire logic [AW-1:0] addr_x,
  input  wire logic [AW-1:0] addr_y,
  output logic      [15:0]   op_a,
  output logic      [15:0]   op_b
);
  // no wait state on the two operand buses
  assign op_a = 16'(addr_x);
  assign op_b = 16'(addr_y);
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mcd_pkg::*;
  logic        ref_clk, sys_rst, psel, penable, pwrite, cmd_valid, cmd_signed;
  logic        intr_pend, cmd_scale, cmd_pmove, cmd_rep, pready, pslverr;
  logic        cmd_ready, res_valid, trap_b, mv_valid, irq, t, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] op_a, op_b, res_data, addr_x, addr_y, mv_addr, mv_data, r;
  logic [33:0] m;
  logic [3:0]  cmd_shift;
  logic [2:0]  cmd_sel;
  mcd_op_type  cmd_op;
  mcd_pm_type  cmd_mode_x, cmd_mode_y;
  int          errors, n_compared, cycles;
  mcd_top dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cmd_valid, .cmd_op, .cmd_signed, .cmd_scale,
    .cmd_pmove, .cmd_rep, .cmd_shift, .cmd_sel, .cmd_mode_x, .cmd_mode_y, .op_a,
    .op_b, .intr_pend, .cmd_ready, .res_valid, .res_data, .trap_b, .addr_x,
    .addr_y, .mv_valid, .mv_addr, .mv_data, .irq);
  mcd_mem_model mem (.addr_x, .addr_y, .op_a, .op_b);
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready; data and error taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // look between edges, where the registered answer has settled
    @(negedge ref_clk);
    while (pready !== 1'b1)
      @(negedge ref_clk);
    rd = prdata;
    e = pslverr;
    @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // issue one command, count edges from the take edge to the result
  task automatic run(input mcd_op_type op, input logic sg, input mcd_pm_type mx);
    int n;
    @(posedge ref_clk);
    cmd_op <= op;
    cmd_signed <= sg;
    cmd_mode_x <= mx;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (res_valid !== 1'b1);
    chk(40'(n), 40'd3);
    r = res_data;
    t = trap_b;
    m = {cmd_ready, mv_valid, mv_addr, mv_data};
  endtask
  // reset values and an unmapped address
  task automatic t_regs;
    apb(1'b0, MCD_STAT_OFS, 32'h0);
    chk(40'(rd), 40'h0);
    apb(1'b0, MCD_REPW_OFS, 32'h0);
    chk(40'(rd), 40'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk(40'({e, rd}), 40'h1_0000_0000);
  endtask
  // signed with trap on negative, then unsigned on the same operands
  task automatic t_mul;
    apb(1'b1, MCD_CTRL_OFS, 32'h1);
    apb(1'b1, MCD_PTR_OFS, 32'h0003_fffe);
    run(MCD_OP_MUL, 1'b1, MCD_PM_INC);
    chk(40'({t, r, addr_x}), 40'h1_ffff_0000);
    apb(1'b1, MCD_PTR_OFS, 32'h0003_fffe);
    run(MCD_OP_MUL, 1'b0, MCD_PM_NONE);
    chk(40'({t, r, addr_x}), 40'h0_0002_fffe);
  endtask
  // shifted product of two minimum values overflows 32 bits and clamps
  task automatic t_sat;
    apb(1'b1, MCD_CTRL_OFS, 32'h600);
    apb(1'b1, MCD_PTR_OFS, 32'h8000_8000);
    run(MCD_OP_MUL, 1'b1, MCD_PM_NONE);
    chk(40'(r), 40'h7fff);
    apb(1'b1, MCD_IEN_OFS, 32'h2);
    apb(1'b0, MCD_ACCL_OFS, 32'h0);
    chk(40'({irq, rd}), 40'h1_7fff_ffff);
    apb(1'b1, MCD_ICLR_OFS, 32'h2);
    apb(1'b0, MCD_STAT_OFS, 32'h0);
    chk(40'({irq, rd[5]}), 40'h1);
    apb(1'b1, MCD_STAT_OFS, 32'h0);
    apb(1'b0, MCD_STAT_OFS, 32'h0);
    chk(40'(rd[5]), 40'h0);
    cmd_sel <= 3'h4;
    run(MCD_OP_STORE, 1'b0, MCD_PM_NONE);
    chk(40'(r), 40'h0600);
  endtask
  // two repeated products, then a repeat cut short by a pending interrupt
  task automatic t_rep;
    apb(1'b1, MCD_CTRL_OFS, 32'h0);
    apb(1'b1, MCD_REPW_OFS, 32'h1);
    apb(1'b1, MCD_PTR_OFS, 32'h0003_0002);
    cmd_rep <= 1'b1;
    run(MCD_OP_MUL, 1'b0, MCD_PM_INC);
    repeat (2) @(posedge ref_clk);
    apb(1'b0, MCD_ACCL_OFS, 32'h0);
    chk(40'(rd), 40'hc);
    apb(1'b0, MCD_REPW_OFS, 32'h0);
    chk(40'(rd), 40'h0);
    apb(1'b1, MCD_REPW_OFS, 32'h2);
    apb(1'b1, MCD_PTR_OFS, 32'h0003_0002);
    intr_pend <= 1'b1;
    cmd_pmove <= 1'b1;
    run(MCD_OP_MAC, 1'b0, MCD_PM_INC);
    chk(40'(m), 40'h3_0003_0003);
    repeat (2) @(posedge ref_clk);
    apb(1'b0, MCD_ACCL_OFS, 32'h0);
    chk(40'(rd), 40'h12);
    apb(1'b0, MCD_REPW_OFS, 32'h0);
    chk(40'(rd), 40'h2);
    {intr_pend, cmd_pmove, cmd_rep} <= 3'h0;
  endtask
  // shift clipped to eight places, a store of the low word, and a table move
  task automatic t_shift;
    cmd_shift <= 4'hf;
    run(MCD_OP_SHL, 1'b0, MCD_PM_NONE);
    cmd_sel <= 3'h0;
    run(MCD_OP_STORE, 1'b0, MCD_PM_NONE);
    chk(40'(r), 40'h1200);
    run(MCD_OP_MOVE, 1'b0, MCD_PM_INC);
    chk(40'(m), 40'h3_0003_0004);
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      errors++;
      wrap_up();
    end
  end
  initial
  begin
    {psel, penable, pwrite, cmd_valid, cmd_signed, intr_pend} = '0;
    {cmd_scale, cmd_pmove, cmd_rep, paddr, pwdata, cmd_shift, cmd_sel} = '0;
    cmd_op = MCD_OP_MUL;
    cmd_mode_x = MCD_PM_NONE;
    cmd_mode_y = MCD_PM_NONE;
    sys_rst = 1'b1;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_mul();
    t_sat();
    t_rep();
    t_shift();
    wrap_up();
  end
endmodule
